// file: ptp_dummy_unused.sv
// spare file, holds no logic

// file: ptp_modreduce.sv
// module: modulo 2M reduction into -M .. M-1
`timescale 1ns/1ns
module ptp_modreduce (
  input  wire logic signed [ptp_pkg::SW+3:0] val,
  input  wire logic        [3:0]             log2m,
  output logic      signed [ptp_pkg::SW-1:0] red
);
  logic signed [ptp_pkg::SW+3:0] m_val;
  logic signed [ptp_pkg::SW+3:0] sh;
  logic        [ptp_pkg::SW+3:0] mask;

  // add M, keep low log2(2M) bits, subtract M: output in [-M, M)
  always_comb begin
    m_val = (ptp_pkg::SW+4)'(1) <<< log2m;
    mask  = ((ptp_pkg::SW+4)'(1) << (log2m + 4'h1)) - (ptp_pkg::SW+4)'(1);
    sh    = signed'((val + m_val) & mask) - m_val;
    red   = sh[ptp_pkg::SW-1:0];
  end
endmodule : ptp_modreduce

// file: ptp_partner.sv
// link partner model: one decoded header per frame
`timescale 1ns/1ns
module ptp_partner (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       frame_start,
  input  wire logic [3:0] want_set,
  input  wire logic [2:0] want_rate,
  input  wire logic       want_ok,
  input  wire logic       want_lpi,
  output logic            hdr_valid,
  output logic [3:0]      set_id,
  output logic [2:0]      rate,
  output logic            cap_rate,
  output logic            cap_lpi,
  output logic            rem_ok,
  output logic            clk_lock
);
  logic [2:0] cnt_r;
  // header lands three symbols into the frame; request fields carry
  // junk outside hdr_valid so a design that ignores it is caught
  always @(posedge aclk) begin
    cnt_r <= !aresetn ? 3'h0 : frame_start ? 3'h1 : cnt_r + {2'h0, |cnt_r};
    hdr_valid <= aresetn && cnt_r == 3'h2;
    set_id <= !aresetn ? 4'h0 : cnt_r == 3'h2 ? want_set : ~set_id;
    rate <= !aresetn ? 3'h0 : cnt_r == 3'h2 ? want_rate : ~rate;
    cap_rate <= 1'b1;
    cap_lpi <= want_lpi;
    rem_ok <= want_ok;
    clk_lock <= aresetn;
  end
endmodule : ptp_partner

// file: ptp_pkg.sv
// package: constants and types for the link tracking precoder
package ptp_pkg;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COEF0  = 8'h08;
  localparam logic [7:0] ADDR_COEF1  = 8'h0c;
  localparam logic [7:0] ADDR_COEF2  = 8'h10;
  localparam logic [7:0] ADDR_COEF3  = 8'h14;
  localparam logic [7:0] ADDR_PSCALE = 8'h18;
  localparam logic [7:0] ADDR_REQ    = 8'h1c;

  // control register fields
  localparam int CTRL_LOC_CAP_POS   = 0;
  localparam int CTRL_LOC_LPI_POS   = 1;
  localparam int CTRL_LOC_OK_POS    = 2;
  localparam int CTRL_REQ_SET_POS   = 4;
  localparam int CTRL_REQ_RATE_POS  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // datapath sizes
  // ---------------------------------------------------------------------
  localparam int NTAPS     = 4;   // precoder taps
  localparam int SW        = 10;  // sample width, covers -512..511
  localparam int CW        = 8;   // tap coefficient width, Q1.6
  localparam int CFRAC     = 6;
  localparam int SETW      = 4;   // coefficient set identifier width
  localparam int RATEW     = 3;   // spectral efficiency code width

  // spectral efficiency code: alphabet size is 2 << code (2..64)
  localparam logic [RATEW-1:0] RATE_MIN = 3'h0;
  localparam logic [RATEW-1:0] RATE_MAX = 3'h5;
  localparam int M_PILOT1 = 2;
  localparam int M_PILOT2 = 256;

  // clock recovery tolerance in ppm
  localparam int CLK_TOL_PPM = 100;

  // frame data types
  typedef enum logic [2:0] {
    DT_SYNC    = 3'h0,
    DT_TRAIN   = 3'h1,
    DT_HEADER  = 3'h2,
    DT_ZERO    = 3'h3,
    DT_PAYLOAD = 3'h4,
    DT_OFF     = 3'h5
  } ptp_dtype_type;

  // link monitor states
  typedef enum logic [2:0] {
    LS_FAIL = 3'b001,
    LS_INIT = 3'b010,
    LS_OK   = 3'b100
  } ptp_link_type;

endpackage : ptp_pkg

// file: ptp_top.sv
// module: tracking control, link monitor and transmit precoder
//
// Behaviour
// - announce coefficient set one frame before use
// - set id keeps partner taps matching receiver
// - coefficient requests go out in header bits
// - announce new rate one frame ahead
// - both capable: start at minimum rate
// - then change rate only on partner request
// - own rate requests go in header bits
// - receive config follows last decoded header
// - same machines for start-up and tracking
// - receiver estimates coefficients (software supplied)
// - link good only when both ends good
// - link failure stops normal data
// - clock recovery tolerates 100 ppm offset
// - subtract feedback, reduce into -M..M-1
// - output is reduced value times scale
// - symbols are odd levels within alphabet
// - alphabet two for pilot1/header, 256 pilot2
// - zero type feeds zero symbol
// - payload alphabet between 2 and 64
// - payload alphabet fixed over a frame
// - taps zero except payload
// - report link change with FAIL or OK
// - local status out, remote status in header
// - low power idle only when link good
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module ptp_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite slave
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // transmit symbol stream
  input  wire logic                          tx_valid,
  input  wire logic signed [8:0]             tx_symbol,
  input  wire logic [2:0]                    tx_dtype,
  input  wire logic                          tx_frame_start,
  output logic                               tx_out_valid,
  output logic signed [15:0]                 tx_sample,
  // header fields decoded from the partner
  input  wire logic                          rx_hdr_valid,
  input  wire logic [3:0]                    rx_coef_set_request_id,
  input  wire logic [2:0]                    rx_rate_request,
  input  wire logic                          rx_rate_adapt_capability,
  input  wire logic                          rx_low_power_capability,
  input  wire logic                          rx_status_field,
  input  wire logic                          rx_clock_lock,
  // header fields to send to the partner
  output logic [3:0]                         tx_coef_set_announce,
  output logic [2:0]                         tx_rate_announce,
  output logic [3:0]                         tx_coef_set_request_id,
  output logic [2:0]                         tx_rate_request,
  output logic                               tx_rate_adapt_capability,
  output logic                               tx_rx_status_field,
  // receive configuration and monitor
  output logic [2:0]                         rx_rate_cfg,
  output logic                               link_change_report,
  output logic                               link_ok,
  output logic                               data_enable,
  output logic                               low_power_idle_en
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  localparam int NT = ptp_pkg::NTAPS;
  localparam int SW = ptp_pkg::SW;
  localparam int CW = ptp_pkg::CW;

  typedef struct packed {
    logic                                aw_got;
    logic [7:0]                          aw_addr;
    logic                                w_got;
    logic [31:0]                         w_data;
    logic [3:0]                          w_strb;
    logic                                bvalid;
    logic                                rvalid;
    logic [31:0]                         rdata;
    logic [1:0]                          rresp;
    logic [31:0]                         ctrl;
    logic [NT*CW-1:0]                    coef_sw;
    logic [15:0]                         pscale;
    logic [3:0]                          set_req;
    logic [3:0]                          set_pend;
    logic                                set_pend_v;
    logic [3:0]                          set_cur;
    logic [NT*CW-1:0]                    coef_pend;
    logic [NT*CW-1:0]                    coef_cur;
    logic [2:0]                          rate_pend;
    logic                                rate_pend_v;
    logic [2:0]                          rate_cur;
    logic                                abr_on;
    logic [2:0]                          rx_rate;
    logic                                rem_ok;
    logic                                rem_lpi;
    ptp_pkg::ptp_link_type               lstate;
    logic                                lchg;
    logic [NT*ptp_pkg::SW-1:0]           hist;
    logic                                oval;
    logic signed [15:0]                  sample;
    logic                                lpi_en;
  } ptp_state_type;

  ptp_state_type s_r;
  ptp_state_type s_nxt;

  // ---------------------------------------------------------------------
  // precoder datapath
  // ---------------------------------------------------------------------
  logic signed [SW+3:0]         acc;
  logic signed [SW-1:0]         reduced;
  logic [3:0]                   log2m;
  logic signed [8:0]            sym_in;
  logic signed [NT*(SW+CW)-1:0] prods;
  logic                         use_taps;

  // taps only on payload, pilots and header run unprecoded
  assign use_taps = (tx_dtype == ptp_pkg::DT_PAYLOAD);

  // alphabet size per data type, payload from the live rate only
  always_comb begin
    case (tx_dtype)
      ptp_pkg::DT_TRAIN:   log2m = 4'h8;
      ptp_pkg::DT_PAYLOAD: log2m = {1'b0, s_r.rate_cur} + 4'h1;
      default:             log2m = 4'h1;
    endcase
  end

  // zero type forces a zero symbol
  assign sym_in = (tx_dtype == ptp_pkg::DT_ZERO) ? 9'sh000 : tx_symbol;

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tap
      assign prods[g*(SW+CW) +: SW+CW] =
        signed'(s_r.hist[g*SW +: SW]) * signed'(s_r.coef_cur[g*CW +: CW]);
    end
  endgenerate

  // subtract weighted past outputs, taps are Q1.6
  always_comb begin
    logic signed [SW+CW+2:0] fb;
    fb = '0;
    for (int i = 0; i < NT; i++) begin
      fb = fb + (SW+CW+3)'(signed'(prods[i*(SW+CW) +: SW+CW]));
    end
    if (!use_taps) begin
      fb = '0;
    end
    acc = (SW+4)'(signed'(sym_in)) - (SW+4)'(fb >>> ptp_pkg::CFRAC);
  end

  ptp_modreduce u_mod (
    .val   (acc),
    .log2m (log2m),
    .red   (reduced)
  );

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  logic                          wr_fire;
  logic                          both_cap;
  logic                          loc_ok;
  logic signed [SW+15:0]         scaled;

  assign loc_ok   = s_r.ctrl[ptp_pkg::CTRL_LOC_OK_POS] & rx_clock_lock;
  assign both_cap = s_r.ctrl[ptp_pkg::CTRL_LOC_CAP_POS]
                  & rx_rate_adapt_capability;
  assign wr_fire  = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
  assign scaled   = signed'(reduced) * signed'({1'b0, s_r.pscale[14:0]});

  always_comb begin
    s_nxt = s_r;
    s_nxt.lchg = 1'b0;

    // axi write: address and data in either order, answer after both
    if (s_axi_awvalid && !s_r.aw_got) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      case (s_r.aw_addr)
        ptp_pkg::ADDR_CTRL:   s_nxt.ctrl = s_r.w_data;
        ptp_pkg::ADDR_COEF0:  s_nxt.coef_sw[0*CW +: CW] = s_r.w_data[CW-1:0];
        ptp_pkg::ADDR_COEF1:  s_nxt.coef_sw[1*CW +: CW] = s_r.w_data[CW-1:0];
        ptp_pkg::ADDR_COEF2:  s_nxt.coef_sw[2*CW +: CW] = s_r.w_data[CW-1:0];
        ptp_pkg::ADDR_COEF3:  s_nxt.coef_sw[3*CW +: CW] = s_r.w_data[CW-1:0];
        ptp_pkg::ADDR_PSCALE: s_nxt.pscale = s_r.w_data[15:0];
        default: ;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // axi read: unmapped addresses read zero with OKAY
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = 2'b00;
      case (s_axi_araddr)
        ptp_pkg::ADDR_CTRL:   s_nxt.rdata = s_r.ctrl;
        ptp_pkg::ADDR_STATUS: s_nxt.rdata = {16'h0000, 1'b0, s_r.rx_rate,
                                s_r.set_cur, 1'b0, s_r.rate_cur,
                                s_r.rem_lpi, s_r.abr_on, s_r.rem_ok,
                                s_r.lstate == ptp_pkg::LS_OK};
        ptp_pkg::ADDR_COEF0:  s_nxt.rdata = 32'(s_r.coef_cur[0*CW +: CW]);
        ptp_pkg::ADDR_COEF1:  s_nxt.rdata = 32'(s_r.coef_cur[1*CW +: CW]);
        ptp_pkg::ADDR_COEF2:  s_nxt.rdata = 32'(s_r.coef_cur[2*CW +: CW]);
        ptp_pkg::ADDR_COEF3:  s_nxt.rdata = 32'(s_r.coef_cur[3*CW +: CW]);
        ptp_pkg::ADDR_PSCALE: s_nxt.rdata = 32'(s_r.pscale);
        ptp_pkg::ADDR_REQ:    s_nxt.rdata = {25'h0, rx_rate_request,
                                rx_coef_set_request_id};
        default:              s_nxt.rdata = 32'h0000_0000;
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // partner header: latch requests and status each frame
    if (rx_hdr_valid) begin
      s_nxt.rx_rate = rx_rate_request;
      s_nxt.rem_ok  = rx_status_field;
      s_nxt.rem_lpi = rx_low_power_capability;
      if (rx_coef_set_request_id != s_r.set_cur) begin
        s_nxt.set_req = rx_coef_set_request_id;
      end
    end

    // frame boundary: apply last frame's announcement, then announce new
    if (tx_valid && tx_frame_start) begin
      if (s_r.set_pend_v) begin
        s_nxt.set_cur  = s_r.set_pend;
        s_nxt.coef_cur = s_r.coef_pend;
      end
      if (s_r.rate_pend_v) begin
        s_nxt.rate_cur = s_r.rate_pend;
      end
      s_nxt.set_pend_v  = 1'b0;
      s_nxt.rate_pend_v = 1'b0;
      // same path at start-up and when tracking
      if (s_r.set_req != s_r.set_cur) begin
        s_nxt.set_pend   = s_r.set_req;
        s_nxt.coef_pend  = s_r.coef_sw;
        s_nxt.set_pend_v = 1'b1;
      end
      if (both_cap && !s_r.abr_on) begin
        s_nxt.abr_on      = 1'b1;
        s_nxt.rate_pend   = ptp_pkg::RATE_MIN;
        s_nxt.rate_pend_v = 1'b1;
      end else if (s_r.abr_on && s_r.rem_ok
                   && s_r.rx_rate != s_r.rate_cur
                   && s_r.rx_rate <= ptp_pkg::RATE_MAX) begin
        s_nxt.rate_pend   = s_r.rx_rate;
        s_nxt.rate_pend_v = 1'b1;
      end
    end
    if (!both_cap) begin
      s_nxt.abr_on = 1'b0;
    end

    // link monitor
    case (s_r.lstate)
      ptp_pkg::LS_FAIL: if (loc_ok) s_nxt.lstate = ptp_pkg::LS_INIT;
      ptp_pkg::LS_INIT: begin
        if (!loc_ok)            s_nxt.lstate = ptp_pkg::LS_FAIL;
        else if (s_r.rem_ok)    s_nxt.lstate = ptp_pkg::LS_OK;
      end
      ptp_pkg::LS_OK: if (!loc_ok || !s_r.rem_ok)
                        s_nxt.lstate = ptp_pkg::LS_FAIL;
      default: s_nxt.lstate = ptp_pkg::LS_FAIL;
    endcase
    s_nxt.lchg = ((s_nxt.lstate == ptp_pkg::LS_OK)
               != (s_r.lstate == ptp_pkg::LS_OK));
    // registered from next values so the pin drops with the link
    s_nxt.lpi_en = s_nxt.ctrl[ptp_pkg::CTRL_LOC_LPI_POS] & s_nxt.rem_lpi
                 & (s_nxt.lstate == ptp_pkg::LS_OK);

    // transmit sample: reduced value times power scale
    s_nxt.oval = tx_valid && (s_r.lstate == ptp_pkg::LS_OK
                 || tx_dtype != ptp_pkg::DT_PAYLOAD)
                 && tx_dtype != ptp_pkg::DT_OFF;
    if (tx_valid) begin
      s_nxt.sample = 16'(scaled >>> 8);
      s_nxt.hist   = {s_r.hist[(NT-1)*SW-1:0], reduced};
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r        <= '0;
      s_r.ctrl   <= ptp_pkg::CTRL_RESET;
      s_r.lstate <= ptp_pkg::LS_FAIL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------------
  assign s_axi_awready          = ~s_r.aw_got;
  assign s_axi_wready           = ~s_r.w_got;
  assign s_axi_bvalid           = s_r.bvalid;
  assign s_axi_bresp            = 2'b00;
  assign s_axi_arready          = ~s_r.rvalid;
  assign s_axi_rvalid           = s_r.rvalid;
  assign s_axi_rdata            = s_r.rdata;
  assign s_axi_rresp            = s_r.rresp;
  assign tx_out_valid           = s_r.oval;
  assign tx_sample              = s_r.sample;
  assign tx_coef_set_announce   = s_r.set_pend;
  assign tx_rate_announce       = s_r.rate_pend;
  assign tx_coef_set_request_id = s_r.ctrl[7:4];
  assign tx_rate_request        = s_r.ctrl[10:8];
  assign tx_rate_adapt_capability = s_r.ctrl[ptp_pkg::CTRL_LOC_CAP_POS];
  assign tx_rx_status_field     = s_r.ctrl[ptp_pkg::CTRL_LOC_OK_POS];
  assign rx_rate_cfg            = s_r.rx_rate;
  assign link_change_report     = s_r.lchg;
  // one-hot state: the good bit is itself a flip-flop
  assign link_ok                = s_r.lstate[2];
  assign data_enable            = s_r.lstate[2];
  assign low_power_idle_en      = s_r.lpi_en;
  // are kept by the clock recovery and symbol source outside

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb_chk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_frame_announce;
    tx_valid && tx_frame_start && s_r.set_pend_v;
  endsequence

  chk_set_apply: assert property (
    seq_frame_announce |=> s_r.set_cur == $past(s_r.set_pend))
    else $error("coefficient set not applied at frame start");

  chk_link_both: assert property (
    s_r.lstate == ptp_pkg::LS_OK |-> $past(s_r.rem_ok))
    else $error("link good without remote status");

  chk_rate_hold: assert property (
    !(tx_valid && tx_frame_start) |=> $stable(s_r.rate_cur))
    else $error("rate changed inside a frame");

  chk_rate_range: assert property (
    s_r.rate_cur <= ptp_pkg::RATE_MAX)
    else $error("payload alphabet above 64");

  chk_change_pulse: assert property (
    $changed(link_ok) |-> link_change_report)
    else $error("link change not reported");

  chk_lpi_gate: assert property (
    low_power_idle_en |-> link_ok && s_r.rem_lpi)
    else $error("low power idle while link not good");

  // the sample is one cycle behind its symbol, so is the link it saw
  chk_data_stop: assert property (
    tx_out_valid && !$past(link_ok)
    |-> $past(tx_dtype) != ptp_pkg::DT_PAYLOAD)
    else $error("payload sent with link failed");

  // signed compare: an unsigned bound would pass any negative value
  chk_mod_range: assert property (
    tx_valid |-> (int'(reduced) >= -(1 <<< log2m))
              && (int'(reduced) < (1 <<< log2m)))
    else $error("precoder output outside alphabet range");

endmodule : ptp_top

// file: tb_top.sv
// testbench: register access, link monitor, rate and precoder stream
`timescale 1ns/1ns
module tb_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h0000_f68f;
  logic [3:0] s_axi_wstrb = 4'hf, w_set = 0;
  logic tx_valid = 0, tx_frame_start = 0, w_ok = 0, w_lpi = 0;
  logic signed [8:0] tx_symbol = 0;
  logic [2:0] tx_dtype = 0, w_rate = 0, rx_rate_request, tx_rate_request;
  logic [2:0] tx_rate_announce, rx_rate_cfg;
  logic [3:0] rx_coef_set_request_id, tx_coef_set_request_id;
  logic [3:0] tx_coef_set_announce;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_out_valid, rx_hdr_valid, rx_rate_adapt_capability;
  logic rx_low_power_capability, rx_status_field, rx_clock_lock;
  logic tx_rate_adapt_capability, tx_rx_status_field, link_change_report;
  logic link_ok, data_enable, low_power_idle_en;
  logic signed [15:0] tx_sample;
  logic signed [15:0] exp_q[$];
  int n_fail = 0, n_tests = 0, n_chg = 0;

  always #5 aclk = ~aclk;

  ptp_top i_ptp_top (.*);
  ptp_partner i_ptp_partner (.aclk(aclk), .aresetn(aresetn),
    .frame_start(tx_frame_start), .want_set(w_set), .want_rate(w_rate),
    .want_ok(w_ok), .want_lpi(w_lpi), .hdr_valid(rx_hdr_valid),
    .set_id(rx_coef_set_request_id), .rate(rx_rate_request),
    .cap_rate(rx_rate_adapt_capability), .cap_lpi(rx_low_power_capability),
    .rem_ok(rx_status_field), .clk_lock(rx_clock_lock));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // modulo fold then scale by 0x180 in Q7.8
  function automatic logic signed [15:0] ref_smp(input int a, input int m);
    int r;
    r = ((a + m) % (2 * m) + 2 * m) % (2 * m) - m;
    return 16'((r * 384) >>> 8);
  endfunction : ref_smp

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_smp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: sample %h expected %h", $time, got, exp);
    end
  endtask : cmp_smp

  // ---------------------------------------------------------------------
  // bus and stream drivers
  // ---------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    cmp({30'h0, s_axi_bresp}, 32'h0000_0000);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    cmp(s_axi_rdata, e);
    cmp({30'h0, s_axi_rresp}, 32'h0000_0000);
  endtask : rchk

  // frame: sync, train, header, zero, then eight payload symbols;
  // symbols other than training range wider than M so the fold is exercised
  task automatic frames(input int m, input int nf);
    int i, a, mm;
    logic [2:0] d;
    @(posedge aclk);
    for (i = 0; i < 12 * nf; i++) begin
      seed = xs(seed);
      d = (i % 12) < 4 ? 3'(i % 12) : 3'h4;
      mm = d == 3'h1 ? 256 : (d == 3'h4 ? m : 2);
      a = d == 3'h1 ? 2 * int'(seed % 256) - 255 : 2 * int'(seed % 64) - 63;
      tx_valid <= 1;
      tx_frame_start <= (i % 12) == 0;
      tx_dtype <= d;
      tx_symbol <= 9'(a);
      exp_q.push_back(d == 3'h3 ? 16'sh0000 : ref_smp(a, mm));
      @(posedge aclk);
    end
    tx_valid <= 0;
    tx_frame_start <= 0;
  endtask : frames

  // bare frame starts: the partner answers with a header while the
  // design, seeing tx_valid low, neither frames nor emits anything
  task automatic hdr_kick(input int n);
    repeat (n) begin
      @(posedge aclk);
      tx_frame_start <= 1;
      @(posedge aclk);
      tx_frame_start <= 0;
      repeat (6) @(posedge aclk);
    end
  endtask : hdr_kick

  // scoreboard: every output sample takes the oldest expectation
  always @(posedge aclk) begin
    if (link_change_report === 1'b1) n_chg++;
    if (tx_out_valid === 1'b1)
      cmp_smp(tx_sample, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // watchdog well beyond the few hundred cycles the sequence takes
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    #1 cmp({link_ok, data_enable, tx_rate_announce}, 32'h0000_0000);
    rchk(ptp_pkg::ADDR_STATUS, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wr(ptp_pkg::ADDR_PSCALE, 32'h0000_0180);
    rchk(ptp_pkg::ADDR_PSCALE, 32'h0000_0180);
    wr(ptp_pkg::ADDR_CTRL, 32'h0000_0337);
    wr(8'h40, 32'hffff_ffff);
    rchk(ptp_pkg::ADDR_CTRL, 32'h0000_0337);
    cmp({tx_coef_set_request_id, tx_rate_request}, 32'h0000_001b);
    cmp({tx_rate_adapt_capability, tx_rx_status_field}, 32'h3);
    cmp({link_ok, n_chg[0]}, 32'h0000_0000);
    @(posedge aclk);
    w_ok <= 1;
    hdr_kick(2);
    #1 cmp({link_ok, data_enable, low_power_idle_en}, 32'h6);
    cmp(32'(n_chg), 32'h0000_0001);
    frames(2, 2);
    rchk(ptp_pkg::ADDR_STATUS, 32'h0000_0007);
    w_rate <= 3'h2;
    w_set <= 4'h9;
    frames(2, 1);
    #1 cmp(32'(rx_rate_cfg), 32'h0000_0002);
    frames(2, 1);
    #1 cmp({tx_coef_set_announce, tx_rate_announce}, 32'h0000_004a);
    frames(8, 2);
    rchk(ptp_pkg::ADDR_STATUS, 32'h0000_2927);
    w_lpi <= 1;
    hdr_kick(2);
    #1 cmp(32'(low_power_idle_en), 32'h0000_0001);
    w_ok <= 0;
    hdr_kick(2);
    #1 cmp({link_ok, data_enable, low_power_idle_en}, 32'h0);
    cmp(32'(n_chg), 32'h0000_0002);
    tally_and_finish;
  end
endmodule : tb_top
